// *** hw/suc_pkg.sv ***
// package for the supply class negotiation block on the card side
// assumes a terminal that drives reset, clock and the supply class pins
package suc_pkg;

  // class indication bit positions in the class byte
  localparam int SUC_CLASS_W = 5;
  localparam int SUC_CLASS_A_BIT = 0;
  localparam int SUC_CLASS_B_BIT = 1;
  localparam int SUC_CLASS_C_BIT = 2;
  localparam int SUC_CLASS_D_BIT = 3;
  localparam int SUC_CLASS_E_BIT = 4;

  // classes d and e are reserved and never advertised
  localparam logic [4:0] SUC_CLASS_USABLE = 5'h07;

  // answer-to-reset bytes around the class byte
  localparam logic [7:0] SUC_ATR_TS = 8'h3B;
  localparam logic [7:0] SUC_ATR_T0 = 8'h80;
  localparam logic [7:0] SUC_ATR_TD1 = 8'h80;
  localparam logic [7:0] SUC_ATR_TD2 = 8'h1F;
  localparam logic [1:0] SUC_CLK_STOP_FIELD = 2'h0;
  localparam int SUC_ATR_LEN = 6;
  localparam int SUC_IDX_TS = 0;
  localparam int SUC_IDX_T0 = 1;
  localparam int SUC_IDX_TD1 = 2;
  localparam int SUC_IDX_TD2 = 3;
  localparam int SUC_IDX_TA3 = 4;
  localparam int SUC_IDX_TCK = 5;

  // timing in card clock cycles
  localparam int SUC_ATR_DELAY_CYC = 400;
  localparam int SUC_BYTE_GAP_CYC = 4464;
  localparam int SUC_CNT_W = 16;

  // reset value of the advertised class set
  localparam logic [4:0] SUC_ADV_RESET = 5'h00;

  // commands reported by the card operating logic
  typedef enum logic [2:0] {
    SUC_CMD_NONE,
    SUC_CMD_SELECT,
    SUC_CMD_STATUS,
    SUC_CMD_VERIFY,
    SUC_CMD_APP
  } suc_cmd_t;

  // true when the set bits form one adjacent run
  function automatic logic suc_run_ok(input logic [4:0] cls);
    logic [4:0] low;
    logic [4:0] sum;
    low = cls & (~cls + 5'h01);
    sum = cls + low;
    return (cls != 5'h00) && ((sum & cls) == 5'h00);
  endfunction : suc_run_ok

  // keeps only the lowest set bit
  function automatic logic [4:0] suc_lowest(input logic [4:0] cls);
    return cls & (~cls + 5'h01);
  endfunction : suc_lowest

endpackage : suc_pkg

// *** hw/suc_sync.sv ***
// two flip-flop synchroniser for levels
// assumes each bit is a level that may change at any time
`timescale 1ns/1ps
module suc_sync
  import suc_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : suc_sync

// *** hw/suc_evt_cross.sv ***
// toggle crossing for single-cycle events between two clocks
// assumes events on the source side are spaced by several destination cycles
`timescale 1ns/1ps
module suc_evt_cross
  import suc_pkg::*;
(
  input wire logic src_clk,
  input wire logic src_reset,
  input wire logic src_pulse,
  input wire logic dst_clk,
  input wire logic dst_reset,
  output logic dst_pulse
);

  logic src_tog;
  logic next_src_tog;
  logic dst_meta;
  logic dst_sync;
  logic dst_last;
  logic next_dst_pulse;

  // source toggles once per event
  always_comb
  begin
    next_src_tog = src_tog ^ src_pulse;
  end

  always_ff @(posedge src_clk or posedge src_reset)
  begin
    if (src_reset)
      src_tog <= 1'b0;
    else
      src_tog <= next_src_tog;
  end

  // edge of the synchronised toggle gives one pulse
  always_comb
  begin
    next_dst_pulse = dst_sync ^ dst_last;
  end

  always_ff @(posedge dst_clk or posedge dst_reset)
  begin
    if (dst_reset)
    begin
      dst_meta <= 1'b0;
      dst_sync <= 1'b0;
      dst_last <= 1'b0;
      dst_pulse <= 1'b0;
    end
    else
    begin
      dst_meta <= src_tog;
      dst_sync <= dst_meta;
      dst_last <= dst_sync;
      dst_pulse <= next_dst_pulse;
    end
  end

endmodule : suc_evt_cross

// *** hw/suc_card.sv ***
// card side of supply class negotiation: class byte in the answer-to-reset,
// power budget tracking and application selection state
// assumes the terminal drives card_clk and card_rst_n, and the card
// operating logic on ref_clk reports finished commands
`timescale 1ns/1ps
module suc_card
  import suc_pkg::*;
#(
  parameter int ATR_DELAY = SUC_ATR_DELAY_CYC,
  parameter int BYTE_GAP = SUC_BYTE_GAP_CYC
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic card_clk,
  input wire logic card_rst_n,
  input wire logic [2:0] supply_class,
  input wire logic alt_iface_on,
  input wire logic [4:0] class_support,
  input wire logic cmd_done,
  input wire suc_cmd_t cmd_kind,
  input wire logic cmd_ok,
  input wire logic app_needs_ac,
  output logic [7:0] atr_data,
  output logic atr_valid,
  output logic [4:0] adv_classes,
  output logic class_config_error,
  output logic class_unsupported,
  output logic reduced_power,
  output logic app_selected
);

  typedef enum logic [1:0] {
    SUC_APP_IDLE,
    SUC_APP_PENDING,
    SUC_APP_SELECTED
  } suc_app_t;

  typedef enum logic [1:0] {
    SUC_LNK_OFF,
    SUC_LNK_WAIT,
    SUC_LNK_SEND,
    SUC_LNK_DONE
  } suc_lnk_t;

  // core side state
  suc_app_t app_state;
  suc_app_t next_app_state;
  logic ac_pending;
  logic next_ac_pending;
  logic [4:0] next_adv_classes;
  logic next_class_config_error;
  logic next_class_unsupported;
  logic next_reduced_power;
  logic next_app_selected;
  logic [2:0] supply_class_s;
  logic alt_iface_s;
  logic atr_start_core;

  // link side state
  logic link_reset;
  logic link_reset_meta;
  logic rst_n_s;
  logic [4:0] adv_link_s;
  logic [4:0] adv_link_hold;
  logic [4:0] adv_link;
  logic [4:0] next_adv_link;
  suc_lnk_t lnk_state;
  suc_lnk_t next_lnk_state;
  logic [SUC_CNT_W-1:0] cnt;
  logic [SUC_CNT_W-1:0] next_cnt;
  logic [2:0] byte_idx;
  logic [2:0] next_byte_idx;
  logic [7:0] next_atr_data;
  logic next_atr_valid;
  logic atr_start_link;
  logic next_atr_start_link;
  logic [7:0] class_byte;
  logic [7:0] tck_byte;

  // pins from the terminal side into the core clock
  suc_sync #(.W(3)) u_sync_class (
    .clk(ref_clk),
    .reset(reset),
    .d(supply_class),
    .q(supply_class_s)
  );

  suc_sync #(.W(1)) u_sync_alt (
    .clk(ref_clk),
    .reset(reset),
    .d(alt_iface_on),
    .q(alt_iface_s)
  );

  // link reset: asserts at once, releases on the card clock
  always_ff @(posedge card_clk or posedge reset)
  begin
    if (reset)
    begin
      link_reset_meta <= 1'b1;
      link_reset <= 1'b1;
    end
    else
    begin
      link_reset_meta <= 1'b0;
      link_reset <= link_reset_meta;
    end
  end

  // terminal reset pin and advertised set into the card clock
  suc_sync #(.W(1)) u_sync_rst (
    .clk(card_clk),
    .reset(link_reset),
    .d(card_rst_n),
    .q(rst_n_s)
  );

  suc_sync #(.W(5)) u_sync_adv (
    .clk(card_clk),
    .reset(link_reset),
    .d(adv_classes),
    .q(adv_link_s)
  );

  // start of each answer-to-reset back to the core
  suc_evt_cross u_evt_atr (
    .src_clk(card_clk),
    .src_reset(link_reset),
    .src_pulse(atr_start_link),
    .dst_clk(ref_clk),
    .dst_reset(reset),
    .dst_pulse(atr_start_core)
  );

  // advertised classes: reserved ones dropped, gaps refused
  always_comb
  begin
    next_class_config_error = 1'b0;
    next_adv_classes = class_support & SUC_CLASS_USABLE;
    if (!suc_run_ok(next_adv_classes))
    begin
      next_class_config_error = 1'b1;
      next_adv_classes = suc_lowest(next_adv_classes);
    end
    // flags a terminal class outside the listed set; the terminal restarts from the class byte
    next_class_unsupported = (supply_class_s != 3'h0) &&
                             ((supply_class_s & adv_classes[2:0]) == 3'h0);
  end

  // application selection and power budget
  always_comb
  begin
    next_app_state = app_state;
    next_ac_pending = ac_pending;
    if (atr_start_core)
    begin
      next_app_state = SUC_APP_IDLE;
      next_ac_pending = 1'b0;
    end
    else if (cmd_done && cmd_ok)
    begin
      case (cmd_kind)
        SUC_CMD_SELECT:
        begin
          next_app_state = SUC_APP_PENDING;
          next_ac_pending = app_needs_ac;
        end
        SUC_CMD_VERIFY:
        begin
          if (app_state == SUC_APP_PENDING && ac_pending)
            next_app_state = SUC_APP_SELECTED;
        end
        SUC_CMD_APP:
        begin
          if (app_state == SUC_APP_PENDING && !ac_pending)
            next_app_state = SUC_APP_SELECTED;
        end
        SUC_CMD_STATUS:
        begin
          next_app_state = app_state;
        end
        default:
        begin
          next_app_state = app_state;
        end
      endcase
    end
    next_app_selected = (next_app_state == SUC_APP_SELECTED);
    next_reduced_power = !(next_app_selected || alt_iface_s);
  end

  // core registers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      app_state <= SUC_APP_IDLE;
      ac_pending <= 1'b0;
      adv_classes <= SUC_ADV_RESET;
      class_config_error <= 1'b0;
      class_unsupported <= 1'b0;
      reduced_power <= 1'b1;
      app_selected <= 1'b0;
    end
    else
    begin
      app_state <= next_app_state;
      ac_pending <= next_ac_pending;
      adv_classes <= next_adv_classes;
      class_config_error <= next_class_config_error;
      class_unsupported <= next_class_unsupported;
      reduced_power <= next_reduced_power;
      app_selected <= next_app_selected;
    end
  end

  // class byte and check byte of the answer-to-reset
  always_comb
  begin
    class_byte = {SUC_CLK_STOP_FIELD, 1'b0, adv_link};
    tck_byte = SUC_ATR_T0 ^ SUC_ATR_TD1 ^ SUC_ATR_TD2 ^ class_byte;
  end

  // answer-to-reset sequencer on the terminal clock
  always_comb
  begin
    next_lnk_state = lnk_state;
    next_cnt = cnt;
    next_byte_idx = byte_idx;
    next_atr_data = atr_data;
    next_atr_valid = 1'b0;
    next_atr_start_link = 1'b0;
    // only take the set once two samples agree
    next_adv_link = (adv_link_s == adv_link_hold) ? adv_link_s : adv_link;
    if (!rst_n_s)
    begin
      next_lnk_state = SUC_LNK_OFF;
      next_cnt = '0;
      next_byte_idx = 3'h0;
    end
    else
    begin
      case (lnk_state)
        SUC_LNK_OFF:
        begin
          next_lnk_state = SUC_LNK_WAIT;
          next_cnt = '0;
          next_atr_start_link = 1'b1;
        end
        SUC_LNK_WAIT:
        begin
          next_cnt = cnt + 1'b1;
          if (cnt == SUC_CNT_W'(ATR_DELAY - 1))
          begin
            next_lnk_state = SUC_LNK_SEND;
            next_cnt = '0;
            next_byte_idx = 3'h0;
          end
        end
        SUC_LNK_SEND:
        begin
          next_cnt = cnt + 1'b1;
          if (cnt == '0)
          begin
            next_atr_valid = 1'b1;
            case (byte_idx)
              3'(SUC_IDX_TS): next_atr_data = SUC_ATR_TS;
              3'(SUC_IDX_T0): next_atr_data = SUC_ATR_T0;
              3'(SUC_IDX_TD1): next_atr_data = SUC_ATR_TD1;
              3'(SUC_IDX_TD2): next_atr_data = SUC_ATR_TD2;
              3'(SUC_IDX_TA3): next_atr_data = class_byte;
              3'(SUC_IDX_TCK): next_atr_data = tck_byte;
              default: next_atr_data = 8'h00;
            endcase
          end
          if (cnt == SUC_CNT_W'(BYTE_GAP - 1))
          begin
            next_cnt = '0;
            next_byte_idx = byte_idx + 3'h1;
            if (byte_idx == 3'(SUC_ATR_LEN - 1))
              next_lnk_state = SUC_LNK_DONE;
          end
        end
        SUC_LNK_DONE:
        begin
          next_lnk_state = SUC_LNK_DONE;
        end
        default:
        begin
          next_lnk_state = SUC_LNK_OFF;
        end
      endcase
    end
  end

  // link registers
  always_ff @(posedge card_clk or posedge link_reset)
  begin
    if (link_reset)
    begin
      lnk_state <= SUC_LNK_OFF;
      cnt <= '0;
      byte_idx <= 3'h0;
      atr_data <= 8'h00;
      atr_valid <= 1'b0;
      atr_start_link <= 1'b0;
      adv_link_hold <= SUC_ADV_RESET;
      adv_link <= SUC_ADV_RESET;
    end
    else
    begin
      lnk_state <= next_lnk_state;
      cnt <= next_cnt;
      byte_idx <= next_byte_idx;
      atr_data <= next_atr_data;
      atr_valid <= next_atr_valid;
      atr_start_link <= next_atr_start_link;
      adv_link_hold <= adv_link_s;
      adv_link <= next_adv_link;
    end
  end

endmodule : suc_card

// *** verification/suc_card_properties.sv ***
// concurrent checks on the supply class block, both clock domains
// assumes it is bound onto suc_card and sees only its ports
`timescale 1ns/1ps
module suc_card_properties
  import suc_pkg::*;
#(
  parameter int ATR_DELAY = SUC_ATR_DELAY_CYC,
  parameter int BYTE_GAP = SUC_BYTE_GAP_CYC
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic card_clk,
  input wire logic card_rst_n,
  input wire logic [2:0] supply_class,
  input wire logic alt_iface_on,
  input wire logic [4:0] class_support,
  input wire logic cmd_done,
  input wire suc_cmd_t cmd_kind,
  input wire logic cmd_ok,
  input wire logic app_needs_ac,
  input wire logic [7:0] atr_data,
  input wire logic atr_valid,
  input wire logic [4:0] adv_classes,
  input wire logic class_config_error,
  input wire logic class_unsupported,
  input wire logic reduced_power,
  input wire logic app_selected
);
  // accepted commands
  sequence s_sel(ac);
    cmd_done && cmd_ok && cmd_kind == SUC_CMD_SELECT && app_needs_ac == ac;
  endsequence
  sequence s_run(k);
    cmd_done && cmd_ok && cmd_kind == k;
  endsequence

  a_adv_masked: assert property (@(posedge ref_clk) disable iff (reset)
    adv_classes[4:3] == 2'h0) else $error("reserved class advertised");
  a_err_flag: assert property (@(posedge ref_clk) disable iff (reset)
    (class_support == 5'h05) [*2] |-> class_config_error) else $error("gap not flagged");
  a_err_single: assert property (@(posedge ref_clk) disable iff (reset)
    class_config_error |-> $onehot(adv_classes)) else $error("bad set advertised");
  a_unsup_flag: assert property (@(posedge ref_clk) disable iff (reset)
    (supply_class != 3'h0 && (supply_class & adv_classes[2:0]) == 3'h0) [*5]
    |-> class_unsupported) else $error("unlisted class not flagged");
  a_app_sel: assert property (@(posedge ref_clk) disable iff (reset)
    s_sel(1'b0) ##1 s_run(SUC_CMD_APP) |=> app_selected) else $error("app not selected");
  a_verify_sel: assert property (@(posedge ref_clk) disable iff (reset)
    s_sel(1'b1) ##1 s_run(SUC_CMD_VERIFY) |=> app_selected) else $error("verify ignored");
  a_status_none: assert property (@(posedge ref_clk) disable iff (reset)
    !app_selected ##0 s_run(SUC_CMD_STATUS) |=> !app_selected) else $error("status selects");
  a_sel_full: assert property (@(posedge ref_clk) disable iff (reset)
    app_selected |-> !reduced_power) else $error("budget kept reduced");
  a_alt_full: assert property (@(posedge ref_clk) disable iff (reset)
    alt_iface_on [*4] |-> !reduced_power) else $error("alt budget missing");
  a_hold_reduced: assert property (@(posedge ref_clk) disable iff (reset)
    (!alt_iface_on && !app_selected) [*4] |-> reduced_power) else $error("budget raised early");
  a_atr_pulse: assert property (@(posedge card_clk) disable iff (reset)
    atr_valid |=> !atr_valid) else $error("byte strobe too long");
endmodule : suc_card_properties

bind suc_card suc_card_properties #(.ATR_DELAY(ATR_DELAY), .BYTE_GAP(BYTE_GAP)) u_props (.*);

// *** verification/suc_term.sv ***
// terminal model: powers the card, releases reset, gathers the answer
// assumes card_clk runs whenever the card is powered
`timescale 1ns/1ps
module suc_term
  import suc_pkg::*;
(
  input wire logic card_clk,
  input wire logic go,
  input wire logic atr_valid,
  input wire logic [7:0] atr_data,
  output logic card_rst_n,
  output logic [2:0] supply_class,
  output logic [7:0] seen [SUC_ATR_LEN],
  output logic done
);
  // card clocks allowed between two answer bytes before giving up
  localparam int WAIT_LIM = 100;

  // one activation at class c, supply settled before reset release;
  // got falls when a byte does not come within the wait limit
  task automatic activate(input logic [2:0] c, output logic got);
    int n;
    card_rst_n <= 1'b0;
    supply_class <= c;
    repeat (6) @(posedge card_clk);
    card_rst_n <= 1'b1;
    got = 1'b1;
    for (int i = 0; i < SUC_ATR_LEN && got; i++)
    begin
      n = 0;
      @(posedge card_clk);
      while (!atr_valid && n < WAIT_LIM)
      begin
        n++;
        @(posedge card_clk);
      end
      got = atr_valid;
      seen[i] <= atr_data;
    end
    @(posedge card_clk);
  endtask : activate

  // lowest voltage first, then retries as the answer demands
  initial
  begin
    logic [2:0] c;
    logic got;
    logic ok;
    int bad;
    card_rst_n = 1'b0;
    supply_class = 3'h0;
    done = 1'b0;
    c = 3'b100;
    ok = 1'b0;
    bad = 0;
    wait (go);
    @(posedge card_clk);
    while (c != 3'h0 && !ok)
    begin
      activate(c, got);
      // silent card: next higher class, none left ends the loop
      if (!got)
        c = c >> 1;
      // check byte makes bytes 1 to 5 sum to zero
      else if (seen[SUC_IDX_TS] != SUC_ATR_TS ||
               (seen[1] ^ seen[2] ^ seen[3] ^ seen[4] ^ seen[5]) != 8'h00)
      begin
        bad++;
        if (bad == 3)
        begin
          bad = 0;
          c = c >> 1;
        end
      end
      else if ((seen[SUC_IDX_TA3][2:0] & c) == 3'h0)
        c = seen[SUC_IDX_TA3][1] ? 3'b010 : (seen[SUC_IDX_TA3][0] ? 3'b001 : 3'h0);
      else
        ok = 1'b1;
    end
    // no usable class left: power the card down and give up
    if (!ok)
    begin
      card_rst_n <= 1'b0;
      supply_class <= 3'h0;
    end
    done <= 1'b1;
  end
endmodule : suc_term

// *** verification/suc_card_bench.sv ***
// self-checking bench for the supply class block
// assumes the package, design, checker and terminal model are compiled first
`timescale 1ns/1ps
module suc_card_bench
  import suc_pkg::*;
;
  logic ref_clk, card_clk, reset, card_rst_n, alt_iface_on, cmd_done, cmd_ok, app_needs_ac;
  logic go, done, atr_valid, class_config_error, class_unsupported, reduced_power, app_selected;
  suc_cmd_t cmd_kind;
  logic [2:0] supply_class;
  logic [4:0] class_support, adv_classes;
  logic [7:0] atr_data;
  logic [7:0] seen [SUC_ATR_LEN];
  int fails, n_tests, cyc;

  suc_card #(.ATR_DELAY(4), .BYTE_GAP(3)) u_suc_card (.ref_clk(ref_clk), .reset(reset),
    .card_clk(card_clk), .card_rst_n(card_rst_n), .supply_class(supply_class),
    .alt_iface_on(alt_iface_on), .class_support(class_support), .cmd_done(cmd_done),
    .cmd_kind(cmd_kind), .cmd_ok(cmd_ok), .app_needs_ac(app_needs_ac), .atr_data(atr_data),
    .atr_valid(atr_valid), .adv_classes(adv_classes), .class_config_error(class_config_error),
    .class_unsupported(class_unsupported), .reduced_power(reduced_power),
    .app_selected(app_selected));
  suc_term u_suc_term (.card_clk(card_clk), .go(go), .atr_valid(atr_valid),
    .atr_data(atr_data), .card_rst_n(card_rst_n), .supply_class(supply_class),
    .seen(seen), .done(done));

  // clocks, the link one offset in phase
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    card_clk = 1'b0;
    #3.3;
    forever #7.5 card_clk = ~card_clk;
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // one command per cycle, left raised for back to back use
  task automatic cmd(input suc_cmd_t k, input logic ac);
    cmd_done = 1'b1;
    cmd_kind = k;
    app_needs_ac = ac;
    @(negedge ref_clk);
  endtask : cmd

  task automatic idle;
    cmd_done = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : idle

  task automatic t_classes;
    logic [4:0] cs [5] = '{5'h01, 5'h06, 5'h05, 5'h1F, 5'h0C};
    logic [4:0] ad [5] = '{5'h01, 5'h06, 5'h01, 5'h07, 5'h04};
    logic er [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      class_support = cs[i];
      repeat (2) @(negedge ref_clk);
      chk8("adv_classes", {3'h0, ad[i]}, {3'h0, adv_classes});
      chk1("class_config_error", er[i], class_config_error);
    end
    $display("test classes done");
  endtask : t_classes

  task automatic t_alt;
    alt_iface_on = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk1("reduced_power", 1'b0, reduced_power);
    alt_iface_on = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk1("reduced_power", 1'b1, reduced_power);
    $display("test alt done");
  endtask : t_alt

  task automatic t_sel;
    cmd_ok = 1'b0;
    cmd(SUC_CMD_SELECT, 1'b0);
    cmd(SUC_CMD_APP, 1'b0);
    idle();
    cmd_ok = 1'b1;
    chk1("app_selected", 1'b0, app_selected);
    cmd(SUC_CMD_SELECT, 1'b0);
    cmd(SUC_CMD_STATUS, 1'b0);
    idle();
    chk1("app_selected", 1'b0, app_selected);
    cmd(SUC_CMD_SELECT, 1'b0);
    cmd(SUC_CMD_APP, 1'b0);
    idle();
    chk1("app_selected", 1'b1, app_selected);
    // no power figure in the select answer: terminal grants the default budget
    chk1("reduced_power", 1'b0, reduced_power);
    $display("test select done");
  endtask : t_sel

  task automatic t_atr;
    logic [7:0] exp [SUC_ATR_LEN];
    exp = '{8'h3B, 8'h80, 8'h80, 8'h1F, 8'h03, 8'h80 ^ 8'h80 ^ 8'h1F ^ 8'h03};
    class_support = 5'h03;
    repeat (4) @(negedge ref_clk);
    go = 1'b1;
    for (int i = 0; i < 3000 && done !== 1'b1 && class_unsupported !== 1'b1; i++)
      @(negedge ref_clk);
    chk1("class_unsupported", 1'b1, class_unsupported);
    for (int i = 0; i < 3000 && done !== 1'b1; i++)
      @(negedge ref_clk);
    chk1("done", 1'b1, done);
    repeat (6) @(negedge ref_clk);
    for (int i = 0; i < SUC_ATR_LEN; i++)
      chk8("atr_byte", exp[i], seen[i]);
    chk8("supply_class", 8'h02, {5'h0, supply_class});
    chk1("class_unsupported", 1'b0, class_unsupported);
    chk1("app_selected", 1'b0, app_selected);
    chk1("reduced_power", 1'b1, reduced_power);
    $display("test answer done");
  endtask : t_atr

  task automatic t_verify;
    cmd(SUC_CMD_SELECT, 1'b1);
    cmd(SUC_CMD_APP, 1'b1);
    idle();
    chk1("app_selected", 1'b0, app_selected);
    cmd(SUC_CMD_SELECT, 1'b1);
    cmd(SUC_CMD_VERIFY, 1'b1);
    idle();
    chk1("app_selected", 1'b1, app_selected);
    $display("test verify done");
  endtask : t_verify

  // reset, then the scenarios in order
  initial
  begin
    reset = 1'b1;
    alt_iface_on = 1'b0;
    cmd_done = 1'b0;
    cmd_kind = SUC_CMD_NONE;
    cmd_ok = 1'b1;
    app_needs_ac = 1'b0;
    class_support = 5'h01;
    go = 1'b0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    chk1("reduced_power", 1'b1, reduced_power);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_classes();
    t_alt();
    t_sel();
    t_atr();
    t_verify();
    conclude();
  end
endmodule : suc_card_bench
